/* File: rtl/eam_mapper.sv */
`timescale 1ns/1ps
// Behaviour
// - Two-bit mode field selects three addressing modes
// - Reset enters 16-bit mode, 64kB spaces
// - Paged mode adds cycle to calls, interrupts
// - Paged mode fetches vectors from page zero
// - Contiguous mode uses full 23-bit counter
// - Contiguous pointer increment takes one extra cycle
// - Bit 22 maps SRAM above 4MB
// - First pointer moves use upper, mid, low
// - Second pointer moves use its three registers
// - Indirect moves use extension, latch, working register
// - Paged fetch upper byte from page extension
// - Extended stack uses high and low registers
// - Stack extend reserves first 1kB SRAM
// - No external strobes for internal accesses
// - Map select places data SRAM three ways
// - Select 11 shares SRAM, no stack
// - CAN RAM placement bit picks range
// - 4MB external, selects per access type
// - Port 2 pins carry address MSB
// - Stack address joins two extension bits
// - Stack extend clear after reset
module eam_mapper
    import eam_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        bus_mux,
    input  wire eam_req_t    req,
    output logic             req_ready,
    output logic             rsp_valid,
    output eam_rsp_t         rsp,
    input  wire logic [7:0]  ext_din,
    output eam_ext_t         ext
);
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ADDR   = 3'b010,
        ST_STROBE = 3'b100
    } eam_state_t;

    logic [7:0]  sfr_reg [NUM_SLOTS];
    eam_state_t  state_reg;
    eam_state_t  state_next;
    logic        ap_valid_reg;
    logic        ap_write_reg;
    logic [3:0]  ap_slot_reg;
    eam_req_t    cur_reg;
    logic [23:0] cur_addr_reg;
    logic        take;
    logic [3:0]  rd_slot;
    logic        addr_take;
    logic [1:0]  am;
    logic        stx;
    logic [1:0]  idm;
    logic        crp;
    logic [23:0] map_addr;
    eam_region_t map_region;
    logic        map_extra;

    // Index decode: word-aligned, upper address bits zero
    function automatic logic [3:0] slot_of(input logic [31:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        if (a[31:10] != 22'h000000 || a[1:0] != 2'b00) begin
            return SLOT_NONE;
        end
        unique case (idx)
            IDX_STK_LO:   return SLOT_STK_LO;
            IDX_DP_LOW:   return SLOT_DP_LOW;
            IDX_DP_MID:   return SLOT_DP_MID;
            IDX_DP1_LOW:  return SLOT_DP1_LOW;
            IDX_DP1_MID:  return SLOT_DP1_MID;
            IDX_DP_UP:    return SLOT_DP_UP;
            IDX_DP1_UP:   return SLOT_DP1_UP;
            IDX_STK_HI:   return SLOT_STK_HI;
            IDX_PAGE_EXT: return SLOT_PAGE_EXT;
            IDX_AH_LATCH: return SLOT_AH_LATCH;
            IDX_MEM_MAP:  return SLOT_MEM_MAP;
            IDX_IND_UP:   return SLOT_IND_UP;
            IDX_ADDR_CTL: return SLOT_ADDR_CTL;
            default:      return SLOT_NONE;
        endcase
    endfunction

    // Window check against a base and size
    function automatic logic in_range(input logic [23:0] a, input logic [23:0] base,
                                      input logic [23:0] size);
        return (a >= base) && (a < base + size);
    endfunction

    // Control fields
    assign am  = sfr_reg[SLOT_ADDR_CTL][AM_LSB+1:AM_LSB];
    assign stx = sfr_reg[SLOT_ADDR_CTL][STX_BIT];
    assign idm = sfr_reg[SLOT_MEM_MAP][IDM_LSB+1:IDM_LSB];
    assign crp = sfr_reg[SLOT_MEM_MAP][CRP_BIT];

    // Bus address phase accepted
    assign addr_take = hsel && hready && htrans[1];
    assign rd_slot   = slot_of(haddr);

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_slot_reg  <= SLOT_NONE;
        end else if (ce && hready) begin
            ap_valid_reg <= addr_take;
            ap_write_reg <= hwrite;
            ap_slot_reg  <= rd_slot;
        end
    end

    // Register writes in the data phase; all clear after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                sfr_reg[i] <= REG_RESET;
            end
        end else if (ce && ap_valid_reg && ap_write_reg && ap_slot_reg != SLOT_NONE) begin
            sfr_reg[ap_slot_reg] <= hwdata[7:0];
        end
    end

    // Read data, forwarded from a write still in its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ce && addr_take && !hwrite) begin
            if (rd_slot == SLOT_NONE) begin
                hrdata <= 32'h00000000;
            end else if (ap_valid_reg && ap_write_reg && ap_slot_reg == rd_slot) begin
                hrdata <= {24'h000000, hwdata[7:0]};
            end else begin
                hrdata <= {24'h000000, sfr_reg[rd_slot]};
            end
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Address formation per access kind and mode
    always_comb begin
        map_addr   = 24'h000000;
        map_region = RGN_EXT;
        unique case (req.kind)
            KIND_FETCH: begin
                if (am == AM_16) begin
                    map_addr = {8'h00, req.pc[15:0]};
                end else if (am == AM_PAGED) begin
                    map_addr = {sfr_reg[SLOT_PAGE_EXT], req.pc[15:0]};
                end else begin
                    map_addr = {1'b0, req.pc};
                end
            end
            KIND_VECTOR: begin
                if (am == AM_PAGED) begin
                    map_addr = {16'h0000, req.pc[7:0]};
                end else if (am == AM_16) begin
                    map_addr = {8'h00, req.pc[15:0]};
                end else begin
                    map_addr = {1'b0, req.pc};
                end
            end
            KIND_PTR0: begin
                map_addr = {(am == AM_16) ? 8'h00 : sfr_reg[SLOT_DP_UP],
                            sfr_reg[SLOT_DP_MID], sfr_reg[SLOT_DP_LOW]};
            end
            KIND_PTR1: begin
                map_addr = {(am == AM_16) ? 8'h00 : sfr_reg[SLOT_DP1_UP],
                            sfr_reg[SLOT_DP1_MID], sfr_reg[SLOT_DP1_LOW]};
            end
            KIND_IND: begin
                map_addr = {(am == AM_16) ? 8'h00 : sfr_reg[SLOT_IND_UP],
                            sfr_reg[SLOT_AH_LATCH], req.ireg};
            end
            KIND_STACK: begin
                map_addr = {16'h0000, sfr_reg[SLOT_STK_LO]};
            end
            default: begin
                map_addr = 24'h000000;
            end
        endcase
        // Internal region decode
        if (req.kind == KIND_STACK) begin
            if (stx && idm != IDM_SHARED) begin
                map_region = RGN_SRAM;
                map_addr   = 24'({14'h0000, sfr_reg[SLOT_STK_HI][1:0], sfr_reg[SLOT_STK_LO]});
                unique case (idm)
                    IDM_TOP64K: map_addr = map_addr + SRAM_BASE_TOP;
                    IDM_BOTTOM: map_addr = map_addr + SRAM_BASE_BOT;
                    default:    map_addr = map_addr + SRAM_BASE_UP;
                endcase
            end else begin
                map_region = RGN_SCRATCH;
            end
        end else if (req.kind == KIND_FETCH || req.kind == KIND_VECTOR) begin
            if (idm == IDM_SHARED && in_range(map_addr, SRAM_BASE_UP, SRAM_SIZE)) begin
                map_region = RGN_SRAM;
            end
        end else begin
            if (in_range(map_addr, crp ? CAN_BASE_UP : CAN_BASE_LOW, CAN_SIZE)) begin
                map_region = RGN_CAN;
            end else if ((idm == IDM_TOP64K && in_range(map_addr, SRAM_BASE_TOP, SRAM_SIZE)) ||
                         (idm == IDM_BOTTOM && in_range(map_addr, SRAM_BASE_BOT, SRAM_SIZE)) ||
                         (idm[1] && in_range(map_addr, SRAM_BASE_UP, SRAM_SIZE))) begin
                map_region = RGN_SRAM;
            end
        end
    end

    // Extra machine cycle requested of the sequencer
    assign map_extra = (am == AM_PAGED && (req.cls == CLS_CALLRET || req.cls == CLS_IRQ)) ||
                       (am[1] && req.cls == CLS_INCDPTR);

    assign take = ce && req.valid && req_ready && state_reg == ST_IDLE;

    // Access sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (take && map_region == RGN_EXT) begin
                    state_next = ST_ADDR;
                end
            end
            ST_ADDR:   state_next = ST_STROBE;
            ST_STROBE: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            req_ready <= 1'b1;
        end else if (ce) begin
            state_reg <= state_next;
            req_ready <= state_next == ST_IDLE;
        end
    end

    // Request capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_reg      <= '0;
            cur_addr_reg <= 24'h000000;
        end else if (take) begin
            cur_reg      <= req;
            cur_addr_reg <= map_addr;
        end
    end

    // Answer: at once for internal hits, after the strobe for external
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp_valid <= 1'b0;
            rsp       <= '0;
        end else if (ce) begin
            rsp_valid <= 1'b0;
            if (take) begin
                rsp.region      <= map_region;
                rsp.addr        <= map_addr;
                rsp.extra_cycle <= map_extra;
                rsp.rdata       <= 8'h00;
                rsp_valid       <= map_region != RGN_EXT;
            end else if (state_reg == ST_STROBE) begin
                rsp.rdata <= cur_reg.write ? 8'h00 : ext_din;
                rsp_valid <= 1'b1;
            end
        end
    end

    // External bus pins; idle unless an external access runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext <= EXT_IDLE;
        end else if (ce) begin
            ext <= EXT_IDLE;
            if (take && map_region == RGN_EXT) begin
                ext.addr_hi  <= map_addr[19:16];
                ext.addr_mid <= map_addr[15:8];
                ext.addr_lo  <= map_addr[7:0];
                ext.ale      <= 1'b1;
                if (bus_mux) begin
                    ext.dout      <= map_addr[7:0];
                    ext.dout_oe_n <= 1'b0;
                end
                if (req.kind == KIND_FETCH || req.kind == KIND_VECTOR) begin
                    ext.chip_select_prog_n[map_addr[21:20]] <= 1'b0;
                end else begin
                    ext.periph_select_data_n[map_addr[21:20]] <= 1'b0;
                end
            end else if (state_reg == ST_ADDR) begin
                ext.addr_hi              <= cur_addr_reg[19:16];
                ext.addr_mid             <= cur_addr_reg[15:8];
                ext.addr_lo              <= cur_addr_reg[7:0];
                ext.chip_select_prog_n   <= ext.chip_select_prog_n;
                ext.periph_select_data_n <= ext.periph_select_data_n;
                if (cur_reg.kind == KIND_FETCH || cur_reg.kind == KIND_VECTOR) begin
                    ext.program_store_strobe_n <= 1'b0;
                end else if (cur_reg.write) begin
                    ext.wr_n      <= 1'b0;
                    ext.dout      <= cur_reg.wdata;
                    ext.dout_oe_n <= 1'b0;
                end else begin
                    ext.rd_n <= 1'b0;
                end
            end
        end
    end

    // Checks
    sequence s_take_ext;
        take && map_region == RGN_EXT;
    endsequence

    sequence s_ext_cycle;
        ext.ale && ext.addr_mid == cur_addr_reg[15:8]
        ##1 !ext.ale && (!ext.rd_n || !ext.wr_n || !ext.program_store_strobe_n)
        ##1 rsp_valid && ext.rd_n && ext.wr_n && ext.program_store_strobe_n;
    endsequence

    AST_EXT_SEQUENCE: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        s_take_ext |=> s_ext_cycle)
        else $error("external access did not run address, strobe, answer");

    AST_INTERNAL_QUIET: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        take && map_region != RGN_EXT |=> rsp_valid && ext.rd_n && ext.wr_n &&
        ext.program_store_strobe_n && !ext.ale && ext.chip_select_prog_n == 4'hf &&
        ext.periph_select_data_n == 4'hf && state_reg == ST_IDLE)
        else $error("internal access touched the external bus");

    AST_PAGED_FETCH: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        take && req.kind == KIND_FETCH && am == AM_PAGED |=>
        rsp.addr == {$past(sfr_reg[SLOT_PAGE_EXT]), $past(req.pc[15:0])})
        else $error("paged fetch upper byte wrong");

    AST_MODE16_FETCH: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        take && req.kind == KIND_FETCH && am == AM_16 |=> rsp.addr[23:16] == 8'h00)
        else $error("16-bit mode fetch above 64kB");

    AST_VECTOR_PAGE0: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        take && req.kind == KIND_VECTOR && am == AM_PAGED |=> rsp.addr[23:8] == 16'h0000)
        else $error("paged vector not in page zero");

    AST_EXTRA_CYCLE: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        take && am == AM_PAGED && req.cls == CLS_CALLRET |=> rsp.extra_cycle)
        else $error("paged call missing extra cycle");

    AST_INC_FIRST_DATA_POINTER: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        take && req.cls == CLS_INCDPTR |=> rsp.extra_cycle == $past(am[1]))
        else $error("pointer increment cycle count wrong");

    AST_FIRST_POINTER: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        take && req.kind == KIND_PTR0 && am != AM_16 |=>
        rsp.addr == {$past(sfr_reg[SLOT_DP_UP]), $past(sfr_reg[SLOT_DP_MID]), $past(sfr_reg[SLOT_DP_LOW])})
        else $error("first pointer address wrong");

    AST_STACK_ADDR: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        take && req.kind == KIND_STACK && stx && idm == IDM_BOTTOM |=>
        rsp.region == RGN_SRAM &&
        rsp.addr == {14'h0000, $past(sfr_reg[SLOT_STK_HI][1:0]), $past(sfr_reg[SLOT_STK_LO])})
        else $error("extended stack address wrong");

    AST_SHARED_NO_STACK: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        take && req.kind == KIND_STACK && idm == IDM_SHARED |=> rsp.region == RGN_SCRATCH)
        else $error("extended stack used in shared mode");
endmodule

/* File: rtl/eam_pkg.sv */
package eam_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_STK_LO    = 8'h81;
    localparam logic [7:0] IDX_DP_LOW    = 8'h82;
    localparam logic [7:0] IDX_DP_MID    = 8'h83;
    localparam logic [7:0] IDX_DP1_LOW   = 8'h84;
    localparam logic [7:0] IDX_DP1_MID   = 8'h85;
    localparam logic [7:0] IDX_DP_UP     = 8'h93;
    localparam logic [7:0] IDX_DP1_UP    = 8'h95;
    localparam logic [7:0] IDX_STK_HI    = 8'h9b;
    localparam logic [7:0] IDX_PAGE_EXT  = 8'h9c;
    localparam logic [7:0] IDX_AH_LATCH  = 8'ha0;
    localparam logic [7:0] IDX_MEM_MAP   = 8'hc6;
    localparam logic [7:0] IDX_IND_UP    = 8'hea;
    localparam logic [7:0] IDX_ADDR_CTL  = 8'hb8;
    // Register file slots
    localparam int         NUM_SLOTS     = 13;
    localparam logic [3:0] SLOT_NONE     = 4'hf;
    localparam logic [3:0] SLOT_STK_LO   = 4'h0;
    localparam logic [3:0] SLOT_DP_LOW   = 4'h1;
    localparam logic [3:0] SLOT_DP_MID   = 4'h2;
    localparam logic [3:0] SLOT_DP1_LOW  = 4'h3;
    localparam logic [3:0] SLOT_DP1_MID  = 4'h4;
    localparam logic [3:0] SLOT_DP_UP    = 4'h5;
    localparam logic [3:0] SLOT_DP1_UP   = 4'h6;
    localparam logic [3:0] SLOT_STK_HI   = 4'h7;
    localparam logic [3:0] SLOT_PAGE_EXT = 4'h8;
    localparam logic [3:0] SLOT_AH_LATCH = 4'h9;
    localparam logic [3:0] SLOT_MEM_MAP  = 4'ha;
    localparam logic [3:0] SLOT_IND_UP   = 4'hb;
    localparam logic [3:0] SLOT_ADDR_CTL = 4'hc;
    localparam logic [7:0] REG_RESET     = 8'h00;
    // Field positions
    localparam int         AM_LSB        = 0;
    localparam int         STX_BIT       = 2;
    localparam int         IDM_LSB       = 6;
    localparam int         CRP_BIT       = 5;
    // Address mode and SRAM map encodings
    localparam logic [1:0] AM_16         = 2'b00;
    localparam logic [1:0] AM_PAGED      = 2'b01;
    localparam logic [1:0] IDM_TOP64K    = 2'b00;
    localparam logic [1:0] IDM_BOTTOM    = 2'b01;
    localparam logic [1:0] IDM_UPPER     = 2'b10;
    localparam logic [1:0] IDM_SHARED    = 2'b11;
    // Internal memory ranges
    localparam logic [23:0] SRAM_BASE_TOP = 24'h00f000;
    localparam logic [23:0] SRAM_BASE_BOT = 24'h000000;
    localparam logic [23:0] SRAM_BASE_UP  = 24'h400000;
    localparam logic [23:0] SRAM_SIZE     = 24'h001000;
    localparam logic [23:0] CAN_BASE_LOW  = 24'h00ee00;
    localparam logic [23:0] CAN_BASE_UP   = 24'h401000;
    localparam logic [23:0] CAN_SIZE      = 24'h000200;

    typedef enum logic [2:0] {
        KIND_FETCH  = 3'h0,
        KIND_VECTOR = 3'h1,
        KIND_PTR0   = 3'h2,
        KIND_PTR1   = 3'h3,
        KIND_IND    = 3'h4,
        KIND_STACK  = 3'h5
    } eam_kind_t;

    typedef enum logic [1:0] {
        CLS_NONE    = 2'h0,
        CLS_CALLRET = 2'h1,
        CLS_INCDPTR = 2'h2,
        CLS_IRQ     = 2'h3
    } eam_class_t;

    typedef enum logic [1:0] {
        RGN_EXT     = 2'h0,
        RGN_SRAM    = 2'h1,
        RGN_CAN     = 2'h2,
        RGN_SCRATCH = 2'h3
    } eam_region_t;

    typedef struct packed {
        logic        valid;
        eam_kind_t   kind;
        logic        write;
        eam_class_t  cls;
        logic [22:0] pc;
        logic [7:0]  ireg;
        logic [7:0]  wdata;
    } eam_req_t;

    typedef struct packed {
        eam_region_t region;
        logic [23:0] addr;
        logic        extra_cycle;
        logic [7:0]  rdata;
    } eam_rsp_t;

    typedef struct packed {
        logic [3:0] addr_hi;
        logic [7:0] addr_mid;
        logic [7:0] addr_lo;
        logic [7:0] dout;
        logic       dout_oe_n;
        logic       ale;
        logic       rd_n;
        logic       wr_n;
        logic       program_store_strobe_n;
        logic [3:0] chip_select_prog_n;
        logic [3:0] periph_select_data_n;
    } eam_ext_t;

    localparam eam_ext_t EXT_IDLE = '{4'h0, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0,
                                      1'b1, 1'b1, 1'b1, 4'hf, 4'hf};
endpackage

/* File: testbench/eam_ext_mem.sv */
`timescale 1ns/1ps
// Byte-wide external memory on the far side of the address/data bus
module eam_ext_mem
    import eam_pkg::*;
(
    input  wire logic     hclk,
    input  wire eam_ext_t ext,
    output logic [7:0]    ext_din
);
    logic [7:0] mem [256];
    logic [7:0] lat;
    logic [7:0] last;

    // Low address latched under ALE, writes stored under the write strobe
    always @(posedge hclk) begin
        if (ext.ale)
            lat <= ext.addr_lo;
        if (!ext.wr_n)
            mem[lat] <= ext.dout;
        if (!ext.rd_n || !ext.program_store_strobe_n)
            last <= ext_din;
    end

    // Data only under a read strobe; a released bus shows a changing pattern
    always_comb begin
        if (!ext.rd_n || !ext.program_store_strobe_n)
            ext_din = mem[lat];
        else
            ext_din = ~last;
    end

    // Known contents so reads can be predicted
    initial begin
        last = 8'h00;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5a;
    end
endmodule

/* File: testbench/extended_address_mapper_tb.sv */
`timescale 1ns/1ps
module extended_address_mapper_tb
    import eam_pkg::*;
;
    logic        hclk, hresetn, ce, hsel, hwrite, bus_mux, hreadyout, hresp, req_ready, rsp_valid;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  ext_din, dm;
    logic [19:0] ea;
    logic [3:0]  cs, ps;
    eam_req_t    req;
    eam_rsp_t    rsp, rs;
    eam_ext_t    ext;
    int          err_total, cmp_count, ns;

    eam_mapper i_eam_mapper (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus_mux(bus_mux), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .ext_din(ext_din), .ext(ext));
    eam_ext_mem i_eam_ext_mem (.hclk(hclk), .ext(ext), .ext_din(ext_din));

    // Bus clock, 100 ns period
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic chk(input logic [39:0] s, input logic [39:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic results;
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One edge, then until the slave shows ready
    task automatic rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            if (++n > 20) begin
                err_total++;
                results();
            end
            @(posedge hclk);
        end
    endtask

    // Single-word transfer, read data left in q
    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        haddr  <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'b10;
        rdy();
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        rdy();
        q = hrdata;
    endtask

    task automatic w(input logic [7:0] idx, input logic [7:0] d);
        ahb(1'b1, idx, d);
    endtask

    task automatic r(input logic [7:0] idx, input logic [7:0] e);
        ahb(1'b0, idx, 8'h00);
        chk(q, {24'h0, e});
    endtask

    task automatic dp(input logic [23:0] a);
        w(IDX_DP_UP, a[23:16]);
        w(IDX_DP_MID, a[15:8]);
        w(IDX_DP_LOW, a[7:0]);
    endtask

    // Core access: count bus activity, capture the address cycle, wait for the answer
    task automatic acc(input eam_kind_t k, input logic wr, input eam_class_t c, input logic [23:0] a,
                       input logic [7:0] d);
        int n;
        req <= '{1'b1, k, wr, c, a[22:0], a[7:0], d};
        @(posedge hclk);
        req.valid <= 1'b0;
        n = 0;
        ns = 0;
        do begin
            @(posedge hclk);
            ns += int'(ext.ale || !ext.rd_n || !ext.wr_n || !ext.program_store_strobe_n);
            if (ext.ale) begin
                ea = {ext.addr_hi, ext.addr_mid, ext.addr_lo};
                cs = ext.chip_select_prog_n;
                ps = ext.periph_select_data_n;
                dm = ext.dout;
            end
            if (++n > 8) begin
                err_total++;
                results();
            end
        end while (rsp_valid !== 1'b1);
        rs = rsp;
    endtask

    // Reset values, unmapped place, read-back
    task automatic t_regs;
        r(IDX_ADDR_CTL, 8'h00);
        r(IDX_MEM_MAP, 8'h00);
        w(8'h00, 8'hff);
        r(8'h00, 8'h00);
        w(IDX_STK_HI, 8'h5a);
        r(IDX_STK_HI, 8'h5a);
    endtask

    // Data moves through both pointers and the indirect path
    task automatic t_ext;
        dp(24'h123456);
        acc(KIND_PTR0, 1'b0, CLS_NONE, 24'h0, 8'h00);
        chk({rs.addr, ps}, {24'h003456, 4'he});
        chk(ea, 20'h03456);
        chk({rs.rdata, 4'(ns)}, {8'h56 ^ 8'h5a, 4'h2});
        w(IDX_ADDR_CTL, 8'h02);
        acc(KIND_PTR0, 1'b1, CLS_INCDPTR, 24'h0, 8'hc3);
        chk({rs.addr, ps, dm}, {24'h123456, 4'hd, 8'h56});
        chk(rs.extra_cycle, 1'b1);
        acc(KIND_PTR0, 1'b0, CLS_NONE, 24'h0, 8'h00);
        chk(rs.rdata, 8'hc3);
        w(IDX_DP1_UP, 8'h21);
        w(IDX_DP1_MID, 8'h43);
        w(IDX_DP1_LOW, 8'h65);
        bus_mux <= 1'b0;
        acc(KIND_PTR1, 1'b0, CLS_NONE, 24'h0, 8'h00);
        chk({rs.addr, ps, dm}, {24'h214365, 4'hb, 8'h00});
        w(IDX_IND_UP, 8'h30);
        w(IDX_AH_LATCH, 8'h0e);
        acc(KIND_IND, 1'b0, CLS_NONE, 24'h77, 8'h00);
        chk({rs.addr, ps, ea[15:8]}, {24'h300e77, 4'h7, 8'h0e});
    endtask

    // Program fetches in each addressing mode
    task automatic t_prog;
        w(IDX_ADDR_CTL, 8'h01);
        w(IDX_PAGE_EXT, 8'h2a);
        acc(KIND_FETCH, 1'b0, CLS_CALLRET, 24'h001234, 8'h00);
        chk({rs.addr, cs, 4'(ns)}, {24'h2a1234, 4'hb, 4'h2});
        chk(rs.extra_cycle, 1'b1);
        acc(KIND_VECTOR, 1'b0, CLS_IRQ, 24'h001234, 8'h00);
        chk({rs.addr, cs, 3'(rs.extra_cycle)}, {24'h000034, 4'he, 3'h1});
        acc(KIND_FETCH, 1'b0, CLS_NONE, 24'h001234, 8'h00);
        chk(rs.extra_cycle, 1'b0);
        w(IDX_ADDR_CTL, 8'h02);
        acc(KIND_FETCH, 1'b0, CLS_CALLRET, 24'h3abcde, 8'h00);
        chk({rs.addr, cs, 3'(rs.extra_cycle)}, {24'h3abcde, 4'h7, 3'h0});
        w(IDX_ADDR_CTL, 8'h00);
        acc(KIND_FETCH, 1'b0, CLS_CALLRET, 24'h2a1234, 8'h00);
        chk({rs.addr, 3'(rs.extra_cycle)}, {24'h001234, 3'h0});
    endtask

    // SRAM placement for every map select, then CAN RAM placement
    task automatic t_map;
        logic [23:0] base [4];
        base = '{SRAM_BASE_TOP, SRAM_BASE_BOT, SRAM_BASE_UP, SRAM_BASE_UP};
        w(IDX_ADDR_CTL, 8'h02);
        for (int m = 0; m < 4; m++) begin
            w(IDX_MEM_MAP, 8'(m << 6));
            dp(base[m] + 24'h10);
            acc(KIND_PTR0, 1'b0, CLS_NONE, 24'h0, 8'h00);
            chk({rs.region, 4'(ns)}, {RGN_SRAM, 4'h0});
        end
        w(IDX_MEM_MAP, 8'h00);
        dp(24'h000010);
        acc(KIND_PTR0, 1'b0, CLS_NONE, 24'h0, 8'h00);
        chk({rs.region, 4'(ns)}, {RGN_EXT, 4'h2});
        dp(24'h00ee10);
        acc(KIND_PTR0, 1'b0, CLS_NONE, 24'h0, 8'h00);
        chk({rs.region, 4'(ns)}, {RGN_CAN, 4'h0});
        w(IDX_MEM_MAP, 8'h20);
        acc(KIND_PTR0, 1'b0, CLS_NONE, 24'h0, 8'h00);
        chk({rs.region, 4'(ns)}, {RGN_EXT, 4'h2});
        dp(24'h401010);
        acc(KIND_PTR0, 1'b0, CLS_NONE, 24'h0, 8'h00);
        chk({rs.region, 4'(ns)}, {RGN_CAN, 4'h0});
    endtask

    // Extended stack, shared mode, bootstrap fetch above 4MB
    task automatic t_stack;
        w(IDX_ADDR_CTL, 8'h06);
        w(IDX_STK_HI, 8'h07);
        w(IDX_STK_LO, 8'h21);
        w(IDX_MEM_MAP, 8'h80);
        acc(KIND_STACK, 1'b0, CLS_NONE, 24'h0, 8'h00);
        chk({rs.region, rs.addr}, {RGN_SRAM, 24'h400321});
        w(IDX_MEM_MAP, 8'h40);
        acc(KIND_STACK, 1'b0, CLS_NONE, 24'h0, 8'h00);
        chk({rs.region, rs.addr}, {RGN_SRAM, 24'h000321});
        w(IDX_MEM_MAP, 8'hc0);
        acc(KIND_STACK, 1'b0, CLS_NONE, 24'h0, 8'h00);
        chk({rs.region, rs.addr}, {RGN_SCRATCH, 24'h000021});
        acc(KIND_FETCH, 1'b0, CLS_NONE, 24'h400010, 8'h00);
        chk({rs.region, 4'(ns)}, {RGN_SRAM, 4'h0});
        w(IDX_ADDR_CTL, 8'h02);
        w(IDX_MEM_MAP, 8'h80);
        acc(KIND_STACK, 1'b0, CLS_NONE, 24'h0, 8'h00);
        chk({rs.region, rs.addr}, {RGN_SCRATCH, 24'h000021});
    endtask

    // Reset, then the scenarios in turn
    initial begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        bus_mux = 1'b1;
        req = '0;
        err_total = 0;
        cmp_count = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_ext();
        t_prog();
        t_map();
        t_stack();
        results();
    end
endmodule
